// ==== pkg/fci_params.svh ====
// Offsets, field positions, masks and reset values of the interlock host
`ifndef FCI_PARAMS_SVH
`define FCI_PARAMS_SVH
// Own register offsets (byte addresses, low eight bits of haddr)
`define FCI_OFS_CMD   8'h00
`define FCI_OFS_ADDR  8'h04
`define FCI_OFS_CLK   8'h08
`define FCI_OFS_STAT  8'h0C
`define FCI_OFS_SHAD  8'h10
// Command word fields
`define FCI_CMD_OP_LSB  0
`define FCI_CMD_BIT_LSB 8
`define FCI_CMD_REG_LSB 12
`define FCI_CMD_VAL_BIT 16
// Clock config fields: bit 0 low-speed oscillator, bits 2:1 divide code
`define FCI_CLK_LOSC_BIT 0
`define FCI_CLK_DIV_LSB  1
// Status fields: error flags start here, write 1 to clear
`define FCI_STAT_ERR_LSB 3
// Bits that need 0 then 1 to set, per device control register
`define FCI_SET_MASK_A 8'h06
`define FCI_SET_MASK_B 8'h08
`define FCI_SET_MASK_C 8'h85
// Bits that need 1 then 0 to clear (the four block locks)
`define FCI_CLR_MASK_B 8'hF0
// Low-current read enable position in control register c
`define FCI_LCR_BIT 3'h7
// Slowest CPU clock allowed with low-current read, in Hz (excluded)
`define FCI_MIN_HZ 3000
// Reset values
`define FCI_SHAD_RST 8'h00
`define FCI_DIV_RST  2'h0
`endif

// ==== pkg/fci_pkg.sv ====
// Types shared by the flash interlock host modules
package fci_pkg;
	// Commands taken through the command register
	typedef enum logic [3:0] {
		op_none   = 4'h0,
		op_setbit = 4'h1,
		op_stop   = 4'h2,
		op_wait   = 4'h3,
		op_blank  = 4'h4,
		op_prog   = 4'h5,
		op_erase  = 4'h6
	} fci_op_t;
	// Device control register selector
	typedef enum logic [1:0] {
		reg_a = 2'h0,
		reg_b = 2'h1,
		reg_c = 2'h2
	} fci_sel_t;
	// Write sequencer states, gray along the path
	typedef enum logic [1:0] {
		seq_idle   = 2'h0,
		seq_second = 2'h1
	} fci_seq_st_t;
endpackage : fci_pkg

// ==== pkg/fci_wr_if.sv ====
// Write request carrier between command decode and write sequencer
`timescale 1ns/100ps
interface fci_wr_if;
	logic       req;
	logic       two;
	logic [1:0] sel;
	logic [7:0] first;
	logic [7:0] last;
	logic       busy;
	modport ctrl (output req, two, sel, first, last, input busy);
	modport seq (input req, two, sel, first, last, output busy);
endinterface : fci_wr_if

// ==== rtl/fci_seq.sv ====
// Device control register write sequencer, single or paired writes
`timescale 1ns/100ps
module fci_seq import fci_pkg::*; (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Requests from command decode
	fci_wr_if.seq           wr,
	// Device register write port
	output      logic       dev_wr_stb,
	output      logic [1:0] dev_wr_sel,
	output      logic [7:0] dev_wr_data,
	output      logic       dev_irq_hold
);
	fci_seq_st_t state_reg;
	logic [7:0]  last_reg;

	// Busy while the hold is up, so no request lands mid-pair
	assign wr.busy = dev_irq_hold;

	// State: a paired request always runs two cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= seq_idle;
		end else begin
			case (state_reg)
			seq_idle: begin
				if (wr.req && wr.two)
					state_reg <= seq_second;
			end
			default: begin
				state_reg <= seq_idle;
			end
			endcase
		end
	end

	// Write strobes on adjacent cycles, nothing between them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_wr_stb  <= 1'b0;
			dev_wr_sel  <= 2'h0;
			dev_wr_data <= 8'h00;
			last_reg    <= 8'h00;
		end else if (state_reg == seq_idle && wr.req) begin
			dev_wr_stb  <= 1'b1;
			dev_wr_sel  <= wr.sel;
			dev_wr_data <= wr.two ? wr.first : wr.last;
			last_reg    <= wr.last;
		end else if (state_reg == seq_second) begin
			dev_wr_stb  <= 1'b1;
			dev_wr_data <= last_reg;
		end else begin
			dev_wr_stb  <= 1'b0;
		end
	end

	// Interrupts and transfer activations held off over the pair
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dev_irq_hold <= 1'b0;
		else
			dev_irq_hold <= (state_reg == seq_idle && wr.req) ||
				(state_reg == seq_second);
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_pair;
		dev_wr_stb ##1 (dev_wr_stb && dev_wr_data != $past(dev_wr_data));
	endsequence
	sequence s_paired_req;
		state_reg == seq_idle && wr.req && wr.two;
	endsequence

	a_pair_back: assert property (s_paired_req |=> s_pair)
		else $error("paired write not back to back");
	a_pair_flip: assert property (s_paired_req |=>
		dev_wr_data[7:0] == $past(wr.first) ##1
		dev_wr_data[7:0] == $past(wr.last, 2))
		else $error("paired write values wrong");
	a_hold_write: assert property (dev_wr_stb |-> dev_irq_hold)
		else $error("device write without interrupt hold");
endmodule : fci_seq

// ==== rtl/fci_ctrl.sv ====
// Host controller driving the flash control interlocks of the device
//
// What this block does
// - Set protected bits by writing 0 then 1
// - Hold interrupts and transfers between paired writes
// - Clear block locks by writing 1 then 0
// - Never program an address twice before erase
// - No stop or wait during erase suspend
// - No stop or wait while sequencer busy
// - Low-current read off before stop or wait
// - No blank check during erase suspend
// - Low-current read only on divided slow oscillator
// - Low-current read never at 3 kHz or below
// - Set clock divider before enabling low-current read
`timescale 1ns/100ps
`include "fci_params.svh"
module fci_ctrl import fci_pkg::*; #(
	parameter int PROG_WORDS = 64,
	parameter int BLK_WORDS  = 16,
	parameter int ADDR_W     = 16,
	parameter int LOCO_HZ    = 125000
) (
	// Clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output      logic              hreadyout,
	output      logic [31:0]       hrdata,
	output      logic              hresp,
	// Device status
	input  wire logic              dev_ready_flag,
	input  wire logic              dev_erase_susp,
	// Device control register writes
	output      logic              dev_wr_stb,
	output      logic [1:0]        dev_wr_sel,
	output      logic [7:0]        dev_wr_data,
	output      logic              dev_irq_hold,
	// Device operation requests
	output      logic              dev_stop_req,
	output      logic              dev_wait_req,
	output      logic              dev_blank_req,
	output      logic              dev_prog_req,
	output      logic              dev_erase_req,
	output      logic [ADDR_W-1:0] dev_addr,
	// Device CPU clock selection
	output      logic              dev_clk_losc,
	output      logic [1:0]        dev_clk_div
);
	localparam int AW = $clog2(PROG_WORDS);
	localparam int BW = $clog2(BLK_WORDS);

	fci_wr_if u_wr ();

	logic                  addr_ph;
	logic                  wr_pend_reg;
	logic                  rd_pend_reg;
	logic [7:0]            ofs_reg;
	logic [7:0]            shad_reg [0:2];
	logic [4:0]            err_reg;
	logic [4:0]            err_set;
	logic [PROG_WORDS-1:0] prog_map_reg;
	logic [AW-1:0]         idx;
	logic                  cmd_wr;
	logic                  clk_wr;
	logic                  busy;
	fci_op_t               op;
	logic [2:0]            bsel;
	logic [1:0]            rsel;
	logic                  bval;
	logic [7:0]            cur;
	logic [7:0]            nxt;
	logic [7:0]            smask;
	logic [7:0]            cmask;
	logic                  lcr_on;
	logic                  lcr_req;
	logic                  clk_ok;
	logic                  freq_ok;
	logic                  lp_ok;
	logic                  dev_op;
	logic                  set_go;
	logic                  stop_go;
	logic                  wait_go;
	logic                  blank_go;
	logic                  prog_go;
	logic                  erase_go;
	logic [31:0]           rdata;
	int                    div_n;

	// Address phase seen by this slave
	assign addr_ph = hsel & htrans[1] & hready;
	assign cmd_wr  = wr_pend_reg && ofs_reg == `FCI_OFS_CMD;
	assign clk_wr  = wr_pend_reg && ofs_reg == `FCI_OFS_CLK;
	assign busy    = u_wr.busy;
	assign idx     = dev_addr[AW-1:0];
	assign lcr_on  = shad_reg[2][`FCI_LCR_BIT];

	// Bus phase tracking; only whole words are expected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			ofs_reg     <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ph & hwrite;
			rd_pend_reg <= addr_ph & ~hwrite;
			if (addr_ph)
				ofs_reg <= haddr[7:0];
		end
	end

	// Reads take one wait state so hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= ~(addr_ph & ~hwrite);
			hresp     <= 1'b0;
			if (rd_pend_reg)
				hrdata <= rdata;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		if (ofs_reg == `FCI_OFS_ADDR)
			rdata = 32'(dev_addr);
		else if (ofs_reg == `FCI_OFS_CLK)
			rdata = {29'h0, dev_clk_div, dev_clk_losc};
		else if (ofs_reg == `FCI_OFS_STAT)
			rdata = {24'h0, err_reg, dev_erase_susp,
				dev_ready_flag, busy};
		else if (ofs_reg == `FCI_OFS_SHAD)
			rdata = {8'h00, shad_reg[2], shad_reg[1], shad_reg[0]};
		else
			rdata = 32'h0000_0000;
	end

	// Command fields
	assign op   = fci_op_t'(hwdata[`FCI_CMD_OP_LSB +: 4]);
	assign bsel = hwdata[`FCI_CMD_BIT_LSB +: 3];
	assign rsel = hwdata[`FCI_CMD_REG_LSB +: 2];
	assign bval = hwdata[`FCI_CMD_VAL_BIT];

	// Target byte and which bits need a paired write
	always_comb begin
		cur   = 8'h00;
		smask = 8'h00;
		cmask = 8'h00;
		if (rsel == reg_a) begin
			cur   = shad_reg[0];
			smask = `FCI_SET_MASK_A;
		end else if (rsel == reg_b) begin
			cur   = shad_reg[1];
			smask = `FCI_SET_MASK_B;
			cmask = `FCI_CLR_MASK_B;
		end else if (rsel == reg_c) begin
			cur   = shad_reg[2];
			smask = `FCI_SET_MASK_C;
		end
		nxt       = cur;
		nxt[bsel] = bval;
	end

	// Paired write: opposite value first, then target value
	assign u_wr.two   = (bval && smask[bsel]) ||
		(!bval && cmask[bsel]);
	assign u_wr.sel   = rsel;
	assign u_wr.last  = nxt;
	assign u_wr.first = {nxt[7:1], nxt[0]} ^ (8'h01 << bsel);
	assign u_wr.req   = set_go;

	// Divide ratio from the clock code; code 0 means undivided
	always_comb begin
		case (dev_clk_div)
		2'h1:    div_n = 4;
		2'h2:    div_n = 8;
		2'h3:    div_n = 16;
		default: div_n = 1;
		endcase
	end

	// Low-current read needs a divided slow oscillator clock
	assign clk_ok  = dev_clk_losc && dev_clk_div != 2'h0;
	assign freq_ok = LOCO_HZ > `FCI_MIN_HZ * div_n;
	assign lcr_req = rsel == reg_c && bsel == `FCI_LCR_BIT && bval;
	// Low-power entry needs idle sequencer, no suspend, no low-current
	assign lp_ok   = dev_ready_flag &&
		!dev_erase_susp &&
		!lcr_on;
	assign dev_op  = cmd_wr && !busy;

	// Accepted commands
	assign set_go   = dev_op && op == op_setbit && rsel != 2'h3 &&
		!(lcr_req && !(clk_ok && freq_ok));
	assign stop_go  = dev_op && op == op_stop && lp_ok;
	assign wait_go  = dev_op && op == op_wait && lp_ok;
	assign blank_go = dev_op && op == op_blank && dev_ready_flag &&
		!dev_erase_susp;
	assign prog_go  = dev_op && op == op_prog && dev_ready_flag &&
		!prog_map_reg[idx];
	assign erase_go = dev_op && op == op_erase && dev_ready_flag;

	// Refusal causes: busy, low power, blank check, program, low-current
	always_comb begin
		err_set    = 5'h00;
		err_set[0] = cmd_wr && op != op_none && (busy ||
			(!dev_ready_flag && (op == op_blank ||
			op == op_prog || op == op_erase)));
		err_set[1] = dev_op && (op == op_stop || op == op_wait) &&
			!lp_ok;
		err_set[2] = dev_op && op == op_blank && dev_ready_flag &&
			dev_erase_susp;
		err_set[3] = dev_op && op == op_prog && dev_ready_flag &&
			prog_map_reg[idx];
		err_set[4] = (dev_op && op == op_setbit && lcr_req &&
			!(clk_ok && freq_ok)) || (clk_wr && lcr_on);
	end

	// Sticky errors; a new refusal wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			err_reg <= 5'h00;
		else if (wr_pend_reg && ofs_reg == `FCI_OFS_STAT)
			err_reg <= (err_reg &
				~hwdata[`FCI_STAT_ERR_LSB +: 5]) | err_set;
		else
			err_reg <= err_reg | err_set;
	end

	// Shadow of device control registers, updated on acceptance
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shad_reg[0] <= `FCI_SHAD_RST;
			shad_reg[1] <= `FCI_SHAD_RST;
			shad_reg[2] <= `FCI_SHAD_RST;
		end else if (set_go) begin
			shad_reg[rsel] <= nxt;
		end
	end

	// Clock config frozen while low-current read is on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_clk_losc <= 1'b0;
			dev_clk_div  <= `FCI_DIV_RST;
		end else if (clk_wr && !lcr_on) begin
			dev_clk_losc <= hwdata[`FCI_CLK_LOSC_BIT];
			dev_clk_div  <= hwdata[`FCI_CLK_DIV_LSB +: 2];
		end
	end

	// Program and erase address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dev_addr <= '0;
		else if (wr_pend_reg && ofs_reg == `FCI_OFS_ADDR)
			dev_addr <= hwdata[ADDR_W-1:0];
	end

	// One-cycle operation requests
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_stop_req  <= 1'b0;
			dev_wait_req  <= 1'b0;
			dev_blank_req <= 1'b0;
			dev_prog_req  <= 1'b0;
			dev_erase_req <= 1'b0;
		end else begin
			dev_stop_req  <= stop_go;
			dev_wait_req  <= wait_go;
			dev_blank_req <= blank_go;
			dev_prog_req  <= prog_go;
			dev_erase_req <= erase_go;
		end
	end

	// Programmed-word map; an erase frees its whole block
	for (genvar g = 0; g < PROG_WORDS; g++) begin : g_map
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				prog_map_reg[g] <= 1'b0;
			else if (prog_go && idx == AW'(g))
				prog_map_reg[g] <= 1'b1;
			else if (erase_go && idx[AW-1:BW] == (AW - BW)'(g >> BW))
				prog_map_reg[g] <= 1'b0;
		end
	end

	fci_seq u_seq (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.wr           (u_wr.seq),
		.dev_wr_stb   (dev_wr_stb),
		.dev_wr_sel   (dev_wr_sel),
		.dev_wr_data  (dev_wr_data),
		.dev_irq_hold (dev_irq_hold)
	);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_lp_req;
		dev_stop_req || dev_wait_req;
	endsequence

	a_lp_no_susp: assert property (s_lp_req |->
		!$past(dev_erase_susp))
		else $error("low power entered during suspend");
	a_lp_ready: assert property (s_lp_req |->
		$past(dev_ready_flag))
		else $error("low power entered while busy");
	a_lp_lcr_off: assert property (s_lp_req |->
		!$past(lcr_on) && !lcr_on)
		else $error("low power entered with low-current read");
	a_blank_susp: assert property (dev_blank_req |->
		!$past(dev_erase_susp))
		else $error("blank check during suspend");
	a_prog_once: assert property (prog_go |=>
		dev_prog_req && prog_map_reg[$past(idx)])
		else $error("programmed word not recorded");
	a_lcr_clk_src: assert property ($rose(lcr_on) |->
		dev_clk_losc && dev_clk_div != 2'h0)
		else $error("low-current read on wrong clock");
	a_lcr_freq: assert property ($rose(lcr_on) |->
		$past(freq_ok))
		else $error("low-current read on too slow clock");
	a_clk_frozen: assert property (lcr_on && $past(lcr_on) |->
		$stable(dev_clk_div) && $stable(dev_clk_losc))
		else $error("clock changed under low-current read");
	a_lcr_paired: assert property ($rose(lcr_on) |->
		(dev_wr_stb && !dev_wr_data[7]) ##1
		(dev_wr_stb && dev_wr_data[7]))
		else $error("low-current enable not paired");
endmodule : fci_ctrl

// ==== sim/fci_dev_model.sv ====
// Behavioural model of the flash control interlocks behind the host
`timescale 1ns/100ps
`include "fci_params.svh"
module fci_dev_model #(
	parameter int BUSY_CYC  = 6,
	parameter bit CODE_PROT = 1'b0
) (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control register writes
	input  wire logic       wr_stb,
	input  wire logic [1:0] wr_sel,
	input  wire logic [7:0] wr_data,
	input  wire logic       irq_hold,
	// Operations and clock source
	input  wire logic       prog_req,
	input  wire logic       erase_req,
	input  wire logic       clk_losc,
	input  wire logic       susp_in,
	// Status and state seen by the bench
	output      logic       ready_flag,
	output      logic       erase_susp,
	output      logic [7:0] reg_a,
	output      logic [7:0] reg_b,
	output      logic [7:0] reg_c,
	output      logic       lcr_active,
	output      int         hold_errs
);
	logic [7:0] prev_data, cur, sm, cm, okset, okclr, nxt;
	logic       prev_hit;
	logic       prev_stb;
	logic [1:0] prev_sel;
	int         busy_cnt;

	// Protected bits reach their guarded value only on an opposite write just before
	always_comb begin
		cur = (wr_sel == 2'h0) ? reg_a : (wr_sel == 2'h1) ? reg_b : reg_c;
		sm = (wr_sel == 2'h0) ? `FCI_SET_MASK_A :
			(wr_sel == 2'h1) ? `FCI_SET_MASK_B : `FCI_SET_MASK_C;
		cm = (wr_sel == 2'h1) ? `FCI_CLR_MASK_B : 8'h00;
		prev_hit = prev_stb && (prev_sel == wr_sel);
		okset = prev_hit ? ~prev_data : 8'h00;
		okclr = prev_hit ? prev_data : 8'h00;
		nxt = (wr_data & ~sm & ~cm) | (sm & wr_data & (okset | cur))
			| (cm & (wr_data | (cur & ~okclr)));
	end

	// Register file; selector 3 is not a register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_a <= 8'h00;
			reg_b <= 8'h00;
			reg_c <= 8'h00;
		end else if (wr_stb) begin
			case (wr_sel)
				2'h0: reg_a <= nxt;
				2'h1: reg_b <= nxt;
				2'h2: reg_c <= nxt;
				default: ;
			endcase
		end
	end

	// Last write, for pair detection and hold checking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_stb <= 1'b0;
			prev_sel <= 2'h0;
			prev_data <= 8'h00;
			hold_errs <= 0;
		end else begin
			prev_stb <= wr_stb;
			prev_sel <= wr_sel;
			prev_data <= wr_data;
			if (wr_stb && irq_hold !== 1'b1)
				hold_errs <= hold_errs + 1;
		end
	end

	// Sequencer busy after program or erase; slow on purpose
	// Code protect refuses every rewrite, so the sequencer stays idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			busy_cnt <= 0;
		else if ((prog_req || erase_req) && !CODE_PROT)
			busy_cnt <= BUSY_CYC;
		else if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
	end

	// Status outputs
	assign ready_flag = (busy_cnt == 0);
	assign erase_susp = susp_in;
	assign lcr_active = clk_losc & reg_c[7];
endmodule : fci_dev_model

// ==== sim/fci_ctrl_tb_top.sv ====
// Self-checking bench for the flash interlock host
`timescale 1ns/100ps
`include "fci_params.svh"
module fci_ctrl_tb_top import fci_pkg::*;;
	typedef struct packed {
		logic [31:0] c;
		logic [31:0] s;
		logic [31:0] n;
	} fci_row_t;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, susp = 1'b0;
	logic        ready, esusp, wstb, whold, lcr;
	logic        stop_r, wait_r, blank_r, prog_r, erase_r, losc;
	logic [1:0]  wsel, div;
	logic [7:0]  wdat, ma, mb, mc;
	logic [15:0] daddr;
	int          mismatches = 0, compares = 0, herr, i, n0;
	int          n_wr = 0, n_stop = 0, n_wait = 0, n_prog = 0, n_erase = 0;
	int          n_blank = 0;
	fci_row_t    rows [7] = '{
		'{32'h00010101, 32'h000002, 32'h2}, '{32'h00010001, 32'h000003, 32'h1},
		'{32'h00011401, 32'h001003, 32'h1}, '{32'h00001401, 32'h000003, 32'h2},
		'{32'h00012201, 32'h040003, 32'h2}, '{32'h00013001, 32'h040003, 32'h0},
		'{32'h00011301, 32'h040803, 32'h2}};

	// Clock, 40 ns period
	always #20 hclk = ~hclk;

	fci_ctrl #(.LOCO_HZ(24000)) DUT (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.dev_ready_flag(ready), .dev_erase_susp(esusp), .dev_wr_stb(wstb),
		.dev_wr_sel(wsel), .dev_wr_data(wdat), .dev_irq_hold(whold),
		.dev_stop_req(stop_r), .dev_wait_req(wait_r),
		.dev_blank_req(blank_r), .dev_prog_req(prog_r),
		.dev_erase_req(erase_r), .dev_addr(daddr), .dev_clk_losc(losc),
		.dev_clk_div(div));

	fci_dev_model model (.hclk(hclk), .hresetn(hresetn), .wr_stb(wstb),
		.wr_sel(wsel), .wr_data(wdat), .irq_hold(whold), .prog_req(prog_r),
		.erase_req(erase_r), .clk_losc(losc), .susp_in(susp),
		.ready_flag(ready), .erase_susp(esusp), .reg_a(ma), .reg_b(mb),
		.reg_c(mc), .lcr_active(lcr), .hold_errs(herr));

	// Pulse counters count cycles high; a paired write holds the strobe two cycles, so it counts two
	always @(posedge hclk) begin
		n_wr += (wstb === 1'b1);
		n_stop += (stop_r === 1'b1);
		n_wait += (wait_r === 1'b1);
		n_blank += (blank_r === 1'b1);
		n_prog += (prog_r === 1'b1);
		n_erase += (erase_r === 1'b1);
	end

	task report_and_stop;
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Bounded wait for hready high at a rising edge
	task wait_rdy;
		for (int k = 0; k < 40; k++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		mismatches++;
		report_and_stop;
	endtask : wait_rdy

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		x = hrdata;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : rd

	// Status check followed by a clear of all error flags
	task stat(input logic [31:0] exp);
		rd(`FCI_OFS_STAT);
		chk("status", x, exp);
		wr(`FCI_OFS_STAT, 32'hF8);
	endtask : stat

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk("dev outputs", {11'h0, wstb, whold, losc, div, daddr}, 32'h0);
		rd(`FCI_OFS_STAT);
		chk("status reset", x, 32'h2);
		rd(`FCI_OFS_CLK);
		chk("clk reset", x, 32'h0);
		// Ordinary set and clear commands
		for (i = 0; i < 7; i++) begin
			n0 = n_wr;
			wr(`FCI_OFS_CMD, rows[i].c);
			repeat (3) @(posedge hclk);
			chk("write count", 32'(n_wr - n0), rows[i].n);
			rd(`FCI_OFS_SHAD);
			chk("shadow", x, rows[i].s);
			chk("device regs", {8'h0, mc, mb, ma}, rows[i].s);
		end
		chk("irq hold", 32'(herr), 32'h0);
		// Second command lands while the pair is in flight
		wr(`FCI_OFS_CMD, 32'h00010201);
		wr(`FCI_OFS_CMD, 32'h00012001);
		repeat (3) @(posedge hclk);
		chk("busy regs", {8'h0, mc, mb, ma}, 32'h040807);
		stat(32'h0A);
		stat(32'h02);
		// Low-current read: slow clock, ratio and order
		wr(`FCI_OFS_CMD, 32'h00012701);
		stat(32'h82);
		wr(`FCI_OFS_CLK, 32'h5);
		wr(`FCI_OFS_CMD, 32'h00012701);
		stat(32'h82);
		wr(`FCI_OFS_CLK, 32'h3);
		wr(`FCI_OFS_CMD, 32'h00012701);
		repeat (3) @(posedge hclk);
		chk("lcr on", {31'h0, lcr}, 32'h1);
		wr(`FCI_OFS_CLK, 32'h7);
		rd(`FCI_OFS_CLK);
		chk("clk kept", x, 32'h3);
		stat(32'h82);
		n0 = n_stop + n_wait;
		wr(`FCI_OFS_CMD, 32'h2);
		stat(32'h12);
		wr(`FCI_OFS_CMD, 32'h00002701);
		wr(`FCI_OFS_CMD, 32'h2);
		wr(`FCI_OFS_CMD, 32'h3);
		// Last pulse follows the taking edge, so let it be counted
		repeat (2) @(posedge hclk);
		chk("stop wait", 32'(n_stop + n_wait - n0), 32'h2);
		// Erase suspended: stop, wait and blank check refused
		susp <= 1'b1;
		n0 = n_stop + n_wait + n_blank;
		wr(`FCI_OFS_CMD, 32'h2);
		wr(`FCI_OFS_CMD, 32'h3);
		wr(`FCI_OFS_CMD, 32'h4);
		stat(32'h36);
		susp <= 1'b0;
		wr(`FCI_OFS_CMD, 32'h4);
		repeat (2) @(posedge hclk);
		chk("susp pulses", 32'(n_stop + n_wait + n_blank - n0), 32'h1);
		// Program, busy, repeat, erase, program again
		n0 = n_prog;
		wr(`FCI_OFS_ADDR, 32'h5);
		wr(`FCI_OFS_CMD, 32'h5);
		wr(`FCI_OFS_CMD, 32'h5);
		repeat (10) @(posedge hclk);
		wr(`FCI_OFS_CMD, 32'h5);
		stat(32'h4A);
		wr(`FCI_OFS_CMD, 32'h6);
		wr(`FCI_OFS_CMD, 32'h2);
		repeat (10) @(posedge hclk);
		stat(32'h12);
		wr(`FCI_OFS_CMD, 32'h5);
		repeat (2) @(posedge hclk);
		chk("prog count", 32'(n_prog - n0), 32'h2);
		chk("erase count", 32'(n_erase), 32'h1);
		// Unmapped place, then a reset in mid-run
		wr(8'h20, 32'hFFFFFFFF);
		rd(8'h20);
		chk("unmapped", x, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`FCI_OFS_SHAD);
		chk("shadow reset", x, 32'h0);
		report_and_stop;
	end
endmodule : fci_ctrl_tb_top
